/* File: design/pie_flag_bank.sv */
// sticky interrupt flags: hardware sets, read of the flag register clears
`timescale 1ns/10ps
module pie_flag_bank
  import pie_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic [7:0] set_in,
  input  wire logic [7:0] clr_in,
  output logic      [7:0] flags_out
);

  logic [7:0] flags_d;
  logic [7:0] flags_q;

  // an event in the clearing cycle survives: set wins
  always_comb begin
    flags_d = ((flags_q & ~clr_in) | set_in) & FLG_IMPL_MASK;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      flags_q <= RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_out = flags_q;

endmodule

/* File: design/pie_irq_mask.sv */
// apb register file and per-source enable gating of peripheral interrupts
`timescale 1ns/10ps
module pie_irq_mask
  import pie_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [DATA_W-1:0] pwdata_in,
  output logic      [DATA_W-1:0] prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              serial_port_event_in,
  input  wire logic              capcmp_one_event_in,
  input  wire logic              timer_two_match_event_in,
  input  wire logic              timer_one_overflow_event_in,
  input  wire logic              osc_fail_event_in,
  input  wire logic              comparator_one_event_in,
  input  wire logic              comparator_two_event_in,
  output logic                   irq_out
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    is_mapped = reg_hit(addr, OFF_CONTROL) || reg_hit(addr, OFF_ENABLE1) ||
                reg_hit(addr, OFF_ENABLE2) || reg_hit(addr, OFF_FLAGS);
  endfunction

  logic access;
  logic wr_acc;
  logic rd_acc;

  // zero wait state: every access phase completes on its first edge
  assign access      = psel_in && penable_in;
  assign wr_acc      = access && pwrite_in;
  assign rd_acc      = access && !pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = access && !is_mapped(paddr_in);

  //////////////////////////////////////////////////////////////////////////////
  // software registers

  logic [7:0] control_d;
  logic [7:0] control_q;
  logic [7:0] enable1_d;
  logic [7:0] enable1_q;
  logic [7:0] enable2_d;
  logic [7:0] enable2_q;

  always_comb begin
    control_d = control_q;
    enable1_d = enable1_q;
    enable2_d = enable2_q;
    if (wr_acc && reg_hit(paddr_in, OFF_CONTROL)) begin
      control_d = 8'h00;
      control_d[CTL_GLOBAL_BIT] = pwdata_in[CTL_GLOBAL_BIT];
      control_d[CTL_PERIPH_BIT] = pwdata_in[CTL_PERIPH_BIT];
    end
    if (wr_acc && reg_hit(paddr_in, OFF_ENABLE1)) begin
      enable1_d = pwdata_in[7:0] & EN1_IMPL_MASK;
    end
    if (wr_acc && reg_hit(paddr_in, OFF_ENABLE2)) begin
      enable2_d = pwdata_in[7:0] & EN2_IMPL_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      control_q <= RST_CONTROL;
      enable1_q <= RST_ENABLE;
      enable2_q <= RST_ENABLE;
    end else begin
      control_q <= control_d;
      enable1_q <= enable1_d;
      enable2_q <= enable2_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flags

  logic [7:0]        flag_set;
  logic [7:0]        flag_clr;
  logic [7:0]        flags;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;

  // flags capture events with no regard to any enable bit
  always_comb begin
    flag_set             = 8'h00;
    flag_set[FLG_TMR1]   = timer_one_overflow_event_in;
    flag_set[FLG_TMR2]   = timer_two_match_event_in;
    flag_set[FLG_CAPCMP] = capcmp_one_event_in;
    flag_set[FLG_SERIAL] = serial_port_event_in;
    flag_set[FLG_CMP1]   = comparator_one_event_in;
    flag_set[FLG_CMP2]   = comparator_two_event_in;
    flag_set[FLG_OSC]    = osc_fail_event_in;
    // clear only what the setup snapshot reported, so an event during the read survives
    flag_clr             = (rd_acc && reg_hit(paddr_in, OFF_FLAGS)) ? rdata_q[7:0] : 8'h00;
  end

  pie_flag_bank u_flags (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .set_in    (flag_set),
    .clr_in    (flag_clr),
    .flags_out (flags)
  );

  //////////////////////////////////////////////////////////////////////////////
  // gating toward the core

  logic [7:0] en_all;
  logic       irq_d;
  logic       irq_q;

  // enables merged into the flag layout; bit 4 has no source here
  assign en_all = {enable2_q[EN2_OSC_BIT], enable2_q[EN2_CMP2_BIT], enable2_q[EN2_CMP1_BIT],
                   1'b0, enable1_q[EN1_SERIAL_BIT], enable1_q[EN1_CAPCMP_BIT],
                   enable1_q[EN1_TMR2_BIT], enable1_q[EN1_TMR1_BIT]};

  // stale flags raise an interrupt as soon as enabled; software must clear first
  always_comb begin
    irq_d = control_q[CTL_GLOBAL_BIT] && control_q[CTL_PERIPH_BIT] && |(flags & en_all);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq_out = irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // read data, registered in the setup phase

  always_comb begin
    rdata_d = rdata_q;
    if (psel_in && !penable_in && !pwrite_in) begin
      rdata_d = '0;
      if (reg_hit(paddr_in, OFF_CONTROL)) rdata_d[7:0] = control_q;
      if (reg_hit(paddr_in, OFF_ENABLE1)) rdata_d[7:0] = enable1_q;
      if (reg_hit(paddr_in, OFF_ENABLE2)) rdata_d[7:0] = enable2_q;
      if (reg_hit(paddr_in, OFF_FLAGS))   rdata_d[7:0] = flags;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata_out = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  logic gate_on;
  assign gate_on = control_q[CTL_GLOBAL_BIT] && control_q[CTL_PERIPH_BIT];

  chk_serial_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    (flags == 8'h08) |=> (irq_out == $past(gate_on && enable1_q[EN1_SERIAL_BIT])))
    else $error("serial request gating wrong");

  chk_capcmp_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    (flags == 8'h04) |=> (irq_out == $past(gate_on && enable1_q[EN1_CAPCMP_BIT])))
    else $error("capture compare gating wrong");

  chk_tmr1_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    (flags == 8'h01) |=> (irq_out == $past(gate_on && enable1_q[EN1_TMR1_BIT])))
    else $error("timer one gating wrong");

  chk_group_block: assert property (@(posedge clk_in) disable iff (srst_in)
    !control_q[CTL_PERIPH_BIT] |=> !irq_out)
    else $error("interrupt with group enable clear");

  chk_osc_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    (flags == 8'h80) |=> (irq_out == $past(gate_on && enable2_q[EN2_OSC_BIT])))
    else $error("osc fail gating wrong");

  chk_cmp2_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    (flags == 8'h40) |=> (irq_out == $past(gate_on && enable2_q[EN2_CMP2_BIT])))
    else $error("comparator two gating wrong");

  chk_cmp1_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    (flags == 8'h20) |=> (irq_out == $past(gate_on && enable2_q[EN2_CMP1_BIT])))
    else $error("comparator one gating wrong");

  chk_flag_sets: assert property (@(posedge clk_in) disable iff (srst_in)
    (osc_fail_event_in && !enable2_q[EN2_OSC_BIT]) |=> flags[FLG_OSC])
    else $error("flag not set while disabled");

  chk_tmr2_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    (flags == 8'h02) |=> (irq_out == $past(gate_on && enable1_q[EN1_TMR2_BIT])))
    else $error("timer two gating wrong");

  // forwarding as a whole
  chk_masked_quiet: assert property (@(posedge clk_in) disable iff (srst_in)
    ((flags & en_all) == 8'h00) |=> !irq_out)
    else $error("interrupt with every flag masked");

  chk_irq_forward: assert property (@(posedge clk_in) disable iff (srst_in)
    (gate_on && (flags & en_all) != 8'h00) |=> irq_out)
    else $error("enabled flag not forwarded");

  chk_global_block: assert property (@(posedge clk_in) disable iff (srst_in)
    !control_q[CTL_GLOBAL_BIT] |=> !irq_out)
    else $error("interrupt with global enable clear");

  chk_irq_cause: assert property (@(posedge clk_in) disable iff (srst_in)
    irq_out |-> $past(gate_on && (flags & en_all) != 8'h00))
    else $error("interrupt without an enabled flag");

  // flag behaviour
  chk_set_wins: assert property (@(posedge clk_in) disable iff (srst_in)
    (flag_set != 8'h00) |=> ((flags & $past(flag_set)) == $past(flag_set)))
    else $error("event lost against a clear");

  chk_flags_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    (flag_set == 8'h00 && flag_clr == 8'h00) |=> (flags == $past(flags)))
    else $error("flag changed with no event and no read");

  chk_read_clears: assert property (@(posedge clk_in) disable iff (srst_in)
    (rd_acc && reg_hit(paddr_in, OFF_FLAGS) && flag_set == 8'h00) |=>
      ((flags & $past(rdata_q[7:0])) == 8'h00))
    else $error("reported flag not cleared by read");

  chk_unreported_kept: assert property (@(posedge clk_in) disable iff (srst_in)
    (rd_acc && reg_hit(paddr_in, OFF_FLAGS)) |=>
      ((($past(flags) & ~$past(rdata_q[7:0])) & ~flags) == 8'h00))
    else $error("unreported flag lost by read");

  chk_flags_ro: assert property (@(posedge clk_in) disable iff (srst_in)
    (wr_acc && reg_hit(paddr_in, OFF_FLAGS)) |=> (flags == ($past(flags) | $past(flag_set))))
    else $error("flag register changed by a write");

  // bus side
  chk_ctl_write: assert property (@(posedge clk_in) disable iff (srst_in)
    (wr_acc && reg_hit(paddr_in, OFF_CONTROL)) |=>
      (control_q[CTL_PERIPH_BIT] == $past(pwdata_in[CTL_PERIPH_BIT])))
    else $error("group enable write lost");

  chk_global_write: assert property (@(posedge clk_in) disable iff (srst_in)
    (wr_acc && reg_hit(paddr_in, OFF_CONTROL)) |=>
      (control_q[CTL_GLOBAL_BIT] == $past(pwdata_in[CTL_GLOBAL_BIT])))
    else $error("global enable write lost");

  chk_en1_write: assert property (@(posedge clk_in) disable iff (srst_in)
    (wr_acc && reg_hit(paddr_in, OFF_ENABLE1)) |=>
      (enable1_q == ($past(pwdata_in[7:0]) & EN1_IMPL_MASK)))
    else $error("first enable register write wrong");

  chk_en2_write: assert property (@(posedge clk_in) disable iff (srst_in)
    (wr_acc && reg_hit(paddr_in, OFF_ENABLE2)) |=>
      (enable2_q == ($past(pwdata_in[7:0]) & EN2_IMPL_MASK)))
    else $error("second enable register write wrong");

  chk_unmapped_inert: assert property (@(posedge clk_in) disable iff (srst_in)
    (wr_acc && !is_mapped(paddr_in)) |=>
      (control_q == $past(control_q) && enable1_q == $past(enable1_q) &&
       enable2_q == $past(enable2_q)))
    else $error("unmapped write changed a register");

  chk_unmapped_zero: assert property (@(posedge clk_in) disable iff (srst_in)
    (psel_in && !penable_in && !pwrite_in && !is_mapped(paddr_in)) |=> (prdata_out == '0))
    else $error("unmapped read data not zero");

  chk_rdata_flags: assert property (@(posedge clk_in) disable iff (srst_in)
    (psel_in && !penable_in && !pwrite_in && reg_hit(paddr_in, OFF_FLAGS)) |=>
      (prdata_out[7:0] == $past(flags)))
    else $error("flag read data wrong");

  chk_rdata_stands: assert property (@(posedge clk_in) disable iff (srst_in)
    access |=> $stable(prdata_out))
    else $error("read data moved in the access phase");

  cov_irq_raised: cover property (@(posedge clk_in) disable iff (srst_in)
    !irq_out ##1 irq_out);
  cov_flag_read: cover property (@(posedge clk_in) disable iff (srst_in)
    (rd_acc && reg_hit(paddr_in, OFF_FLAGS) && flags != 8'h00));
  cov_set_on_clear: cover property (@(posedge clk_in) disable iff (srst_in)
    (rd_acc && reg_hit(paddr_in, OFF_FLAGS) && flag_set != 8'h00));
  cov_group_held: cover property (@(posedge clk_in) disable iff (srst_in)
    (flags != 8'h00 && control_q[CTL_GLOBAL_BIT] && !control_q[CTL_PERIPH_BIT]));
  cov_unmapped_err: cover property (@(posedge clk_in) disable iff (srst_in)
    pslverr_out);

endmodule

/* File: design/pie_pkg.sv */
// constants and register layout for the peripheral interrupt enable mask block
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package pie_pkg;

  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 32;

  // register byte offsets
  localparam logic [7:0]  OFF_CONTROL = 8'h00;
  localparam logic [7:0]  OFF_ENABLE1 = 8'h04;
  localparam logic [7:0]  OFF_ENABLE2 = 8'h08;
  localparam logic [7:0]  OFF_FLAGS   = 8'h0C;

  // interrupt_control_reg fields
  localparam int          CTL_GLOBAL_BIT = 7;
  localparam int          CTL_PERIPH_BIT = 6;

  // first enable register fields
  localparam int          EN1_SERIAL_BIT = 3;
  localparam int          EN1_CAPCMP_BIT = 2;
  localparam int          EN1_TMR2_BIT   = 1;
  localparam int          EN1_TMR1_BIT   = 0;
  localparam logic [7:0]  EN1_IMPL_MASK  = 8'h0F;

  // second enable register fields
  localparam int          EN2_OSC_BIT    = 7;
  localparam int          EN2_CMP2_BIT   = 6;
  localparam int          EN2_CMP1_BIT   = 5;
  localparam logic [7:0]  EN2_IMPL_MASK  = 8'hE0;

  // flag register: same layout as the merged enables
  localparam int          FLG_TMR1   = 0;
  localparam int          FLG_TMR2   = 1;
  localparam int          FLG_CAPCMP = 2;
  localparam int          FLG_SERIAL = 3;
  localparam int          FLG_CMP1   = 5;
  localparam int          FLG_CMP2   = 6;
  localparam int          FLG_OSC    = 7;
  localparam logic [7:0]  FLG_IMPL_MASK = 8'hEF;

  localparam logic [7:0]  RST_CONTROL = 8'h00;
  localparam logic [7:0]  RST_ENABLE  = 8'h00;
  localparam logic [7:0]  RST_FLAGS   = 8'h00;

endpackage

/* File: dv/pie_irq_mask_tb.sv */
// self-checking bench for the peripheral interrupt enable mask block
`timescale 1ns/10ps
module pie_irq_mask_tb;
  import pie_pkg::*;
  logic              clk_in = 1'b0;
  logic              srst_in = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata_out;
  logic              pready_out;
  logic              pslverr_out;
  logic [7:0]        fire = 8'h00;
  logic [6:0]        ev;
  logic              irq_out;
  int                n_mismatch = 0;
  int                compares = 0;
  int                cycles = 0;
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  pie_src_model u_pie_src_model (.clk_in(clk_in), .srst_in(srst_in), .fire_in(fire),
    .serial_port_out(ev[0]), .capcmp_one_out(ev[1]), .timer_two_match_out(ev[2]),
    .timer_one_overflow_out(ev[3]), .osc_fail_out(ev[4]), .comparator_one_out(ev[5]),
    .comparator_two_out(ev[6]));
  pie_irq_mask u_pie_irq_mask (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .serial_port_event_in(ev[0]), .capcmp_one_event_in(ev[1]),
    .timer_two_match_event_in(ev[2]), .timer_one_overflow_event_in(ev[3]),
    .osc_fail_event_in(ev[4]), .comparator_one_event_in(ev[5]),
    .comparator_two_event_in(ev[6]), .irq_out(irq_out));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // values are taken at the edge where pready is sampled high, before any release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    r = prdata_out;
    e = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(what, {24'h0, exp}, r);
    check("pslverr mapped", 32'h0, {31'h0, e});
  endtask
  task automatic fire_irq(input logic [7:0] b, input logic exp);
    @(posedge clk_in);
    fire <= b;
    @(posedge clk_in);
    fire <= 8'h00;
    repeat (3) @(posedge clk_in);
    #1 check("irq_out", {31'h0, exp}, {31'h0, irq_out});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd_chk("control reset", OFF_CONTROL, 8'h00);
    rd_chk("enable1 reset", OFF_ENABLE1, 8'h00);
    rd_chk("enable2 reset", OFF_ENABLE2, 8'h00);
    rd_chk("flags reset", OFF_FLAGS, 8'h00);
    wr(OFF_CONTROL, 8'hFF);
    wr(OFF_ENABLE1, 8'hFF);
    wr(OFF_ENABLE2, 8'hFF);
    wr(OFF_FLAGS, 8'hFF);
    rd_chk("control bits", OFF_CONTROL, 8'hC0);
    rd_chk("enable1 bits", OFF_ENABLE1, 8'h0F);
    rd_chk("enable2 bits", OFF_ENABLE2, 8'hE0);
    rd_chk("flags read only", OFF_FLAGS, 8'h00);
    apb(1'b0, 8'h10, 32'h0, r, e);
    check("unmapped pslverr", 32'h1, {31'h0, e});
    check("unmapped rdata", 32'h0, r);
    apb(1'b1, 8'h10, 32'h0, r, e);
    check("unmapped write pslverr", 32'h1, {31'h0, e});
    rd_chk("enable1 kept", OFF_ENABLE1, 8'h0F);
    wr(OFF_ENABLE1, 8'h00);
    wr(OFF_ENABLE2, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_gating();
    int          bits[7] = '{0, 1, 2, 3, 5, 6, 7};
    logic [7:0]  m;
    logic [7:0]  off;
    foreach (bits[i]) begin
      m = 8'h01 << bits[i];
      off = (bits[i] < 4) ? OFF_ENABLE1 : OFF_ENABLE2;
      wr(OFF_CONTROL, 8'hC0);
      rd_chk("stale flags", OFF_FLAGS, 8'h00);
      wr(off, m);
      fire_irq(m, 1'b1);
      rd_chk("flag of source", OFF_FLAGS, m);
      repeat (2) @(posedge clk_in);
      #1 check("irq after clear", 32'h0, {31'h0, irq_out});
      wr(off, 8'h00);
      fire_irq(m, 1'b0);
      rd_chk("flag while disabled", OFF_FLAGS, m);
      wr(off, m);
      wr(OFF_CONTROL, 8'h80);
      fire_irq(m, 1'b0);
      wr(OFF_CONTROL, 8'hC0);
      repeat (2) @(posedge clk_in);
      #1 check("irq on group enable", 32'h1, {31'h0, irq_out});
      rd_chk("flag kept", OFF_FLAGS, m);
      wr(off, 8'h00);
    end
    $display("test gating done");
  endtask
  // one event lands in the setup cycle of a flag read, another in its access cycle
  task automatic t_read_race();
    logic [31:0] r;
    logic        e;
    @(posedge clk_in);
    fire <= 8'h01;
    fork
      apb(1'b0, OFF_FLAGS, 32'h0, r, e);
      begin
        @(posedge clk_in);
        fire <= 8'h02;
        @(posedge clk_in);
        fire <= 8'h00;
      end
    join
    check("flags before late events", 32'h0, r);
    rd_chk("events during read kept", OFF_FLAGS, 8'h03);
    rd_chk("flags cleared", OFF_FLAGS, 8'h00);
    $display("test read race done");
  endtask
  task automatic t_reset();
    wr(OFF_CONTROL, 8'hC0);
    wr(OFF_ENABLE2, 8'h80);
    fire_irq(8'h80, 1'b1);
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    #1 check("irq after reset", 32'h0, {31'h0, irq_out});
    rd_chk("control after reset", OFF_CONTROL, 8'h00);
    rd_chk("enable2 after reset", OFF_ENABLE2, 8'h00);
    rd_chk("flags after reset", OFF_FLAGS, 8'h00);
    $display("test reset done");
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    t_regs();
    t_gating();
    t_read_race();
    t_reset();
    wrap_up();
  end
endmodule

/* File: dv/pie_src_model.sv */
// model of the peripheral event sources that feed the enable mask block
`timescale 1ns/10ps
module pie_src_model
  import pie_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic [7:0] fire_in,
  output logic            serial_port_out,
  output logic            capcmp_one_out,
  output logic            timer_two_match_out,
  output logic            timer_one_overflow_out,
  output logic            osc_fail_out,
  output logic            comparator_one_out,
  output logic            comparator_two_out
);
  logic [7:0] pulse_q;
  logic [7:0] pulse_d;
  // sources raise events without regard to any enable bit
  always_comb begin
    pulse_d = srst_in ? 8'h00 : fire_in;
  end
  always_ff @(posedge clk_in) begin
    pulse_q <= pulse_d;
  end
  assign timer_one_overflow_out = pulse_q[FLG_TMR1];
  assign timer_two_match_out    = pulse_q[FLG_TMR2];
  assign capcmp_one_out         = pulse_q[FLG_CAPCMP];
  assign serial_port_out        = pulse_q[FLG_SERIAL];
  assign comparator_one_out     = pulse_q[FLG_CMP1];
  assign comparator_two_out     = pulse_q[FLG_CMP2];
  assign osc_fail_out           = pulse_q[FLG_OSC];
endmodule
